// *** logic/wdit_map.svh ***
// Field positions, reset values, keys and timing counts of the timer.
`ifndef WDIT_MAP_SVH
`define WDIT_MAP_SVH

// Control word field positions.
`define WDIT_CLR_MSB      7
`define WDIT_CLR_LSB      4
`define WDIT_EN_BIT       3
`define WDIT_MODE_BIT     2
`define WDIT_INT_MSB      1
`define WDIT_INT_LSB      0

// Reset values.
`define WDIT_CTL_RST      8'h00
`define WDIT_CNT_RST      15'h0000

// Clear keys and the timer-mode clear bit.
`define WDIT_KEY_FIRST    4'ha
`define WDIT_KEY_SECOND   4'h5
`define WDIT_TCLR_BIT     0

// Interval codes and the last count before expiry for each.
`define WDIT_INT_32768    2'h0
`define WDIT_INT_8192     2'h1
`define WDIT_INT_512      2'h2
`define WDIT_INT_64       2'h3
`define WDIT_LAST_32768   15'h7fff
`define WDIT_LAST_8192    15'h1fff
`define WDIT_LAST_512     15'h01ff
`define WDIT_LAST_64      15'h003f

// Reset cause codes for no reset and for a watchdog reset.
`define WDIT_CAUSE_NONE   2'h0
`define WDIT_CAUSE_WDOG   2'h2

// Clock rates in Hz; the key window is half a low-frequency period.
`define WDIT_CLK_HZ       25000000
`define WDIT_LF_HZ        32768
`define WDIT_KEY_WIN_CYC  (`WDIT_CLK_HZ / (2 * `WDIT_LF_HZ))

`endif

// *** logic/wdit_pkg.sv ***
// Types shared by the watchdog and interval timer.
package wdit_pkg;

    typedef enum logic
    {
        WDIT_WATCHDOG = 1'b0,
        WDIT_TIMER    = 1'b1
    } wdit_mode_t;

    typedef enum logic
    {
        WDIT_KEY_IDLE  = 1'b0,
        WDIT_KEY_ARMED = 1'b1
    } wdit_key_t;

    typedef struct packed
    {
        logic [3:0] clr;
        logic       en;
        wdit_mode_t mode;
        logic [1:0] intv;
    } wdit_ctl_t;

endpackage

// *** logic/wdit_lf_sync.sv ***
// Low-frequency clock pin synchroniser and rising-edge tick generator.
`timescale 1ns/10ps
module wdit_lf_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Low-frequency clock pin
    input  wire logic lf_clk,
    // One-cycle pulse on each rising edge
    output logic      lf_tick
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic flt_ff;
    logic tick_ff;
    logic nxt_flt;
    logic nxt_tick;

    // The filtered level only moves once the second and third stages agree.
    always_comb
    begin
        nxt_flt  = flt_ff;
        nxt_tick = 1'b0;
        if (s2_ff == s3_ff)
        begin
            nxt_flt  = s3_ff;
            nxt_tick = s3_ff & ~flt_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            flt_ff  <= 1'b0;
            tick_ff <= 1'b0;
        end
        else
        begin
            s1_ff   <= lf_clk;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            flt_ff  <= nxt_flt;
            tick_ff <= nxt_tick;
        end
    end

    assign lf_tick = tick_ff;

endmodule

// *** logic/wdit_top.sv ***
// Watchdog and interval timer with a 15-bit low-frequency counter.
`timescale 1ns/10ps
`include "wdit_map.svh"
module wdit_top
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Low-frequency clock pin
    input  wire logic       lf_clk,
    // Control register write port
    input  wire logic       ctl_wr,
    input  wire logic [7:0] ctl_wdata,
    // Control register readback
    output logic      [7:0] ctl_rdata,
    // System side
    output logic            wdog_rst_req,
    output logic      [1:0] rst_cause,
    output logic            tmr_irq
);

    localparam logic [8:0] KEY_WIN = 9'(`WDIT_KEY_WIN_CYC);

    logic                  lf_tick;
    wdit_pkg::wdit_ctl_t   wr_ctl;
    logic                  locked;
    logic                  expire;

    logic [14:0]           cnt_ff;
    logic                  en_ff;
    wdit_pkg::wdit_mode_t  mode_ff;
    logic [1:0]            intv_ff;
    wdit_pkg::wdit_key_t   key_ff;
    logic [8:0]            win_ff;
    logic                  pend_ff;
    logic                  rst_ff;
    logic                  irq_ff;
    logic [1:0]            cause_ff;
    logic [7:0]            rdata_ff;

    logic [14:0]           nxt_cnt;
    logic                  nxt_en;
    wdit_pkg::wdit_mode_t  nxt_mode;
    logic [1:0]            nxt_intv;
    wdit_pkg::wdit_key_t   nxt_key;
    logic [8:0]            nxt_win;
    logic                  nxt_pend;
    logic                  nxt_rst;
    logic                  nxt_irq;
    logic [1:0]            nxt_cause;
    logic [7:0]            nxt_rdata;

    // Last count value before the selected interval expires.
    function automatic logic [14:0] last_count(input logic [1:0] code);
        logic [14:0] v;
        v = `WDIT_LAST_32768;
        unique case (code)
            `WDIT_INT_32768: v = `WDIT_LAST_32768;
            `WDIT_INT_8192:  v = `WDIT_LAST_8192;
            `WDIT_INT_512:   v = `WDIT_LAST_512;
            `WDIT_INT_64:    v = `WDIT_LAST_64;
        endcase
        return v;
    endfunction

    wdit_lf_sync u_lf_sync
    (
        .clk     (clk),
        .rstn    (rstn),
        .lf_clk  (lf_clk),
        .lf_tick (lf_tick)
    );

    assign wr_ctl = wdit_pkg::wdit_ctl_t'(ctl_wdata);
    assign locked = en_ff & (mode_ff == wdit_pkg::WDIT_WATCHDOG);
    // The live interval field feeds the compare directly.
    assign expire = lf_tick & en_ff
                    & (cnt_ff == last_count(intv_ff));

    always_comb
    begin
        nxt_cnt   = cnt_ff;
        nxt_en    = en_ff;
        nxt_mode  = mode_ff;
        nxt_intv  = intv_ff;
        nxt_key   = key_ff;
        nxt_win   = win_ff;
        nxt_pend  = pend_ff;
        nxt_rst   = 1'b0;
        nxt_irq   = 1'b0;
        nxt_cause = cause_ff;

        // Counting and expiry.
        if (expire)
        begin
            nxt_cnt = `WDIT_CNT_RST;
            if (mode_ff == wdit_pkg::WDIT_TIMER)
            begin
                nxt_irq = 1'b1;
            end
            else if (key_ff == wdit_pkg::WDIT_KEY_ARMED)
            begin
                // A sequence is in flight; wait for its second key.
                nxt_pend = 1'b1;
            end
            else
            begin
                nxt_rst   = 1'b1;
                nxt_cause = `WDIT_CAUSE_WDOG;
            end
        end
        else if (lf_tick && en_ff)
        begin
            nxt_cnt = cnt_ff + 15'h0001;
        end

        // Key window countdown; a lapsed window with a deferred expiry
        // turns into the reset that was held back.
        if (key_ff == wdit_pkg::WDIT_KEY_ARMED)
        begin
            if (win_ff == 9'h000)
            begin
                nxt_key  = wdit_pkg::WDIT_KEY_IDLE;
                // An expiry in this very cycle is only held in nxt_pend, so
                // it is read before the flag drops or that expiry is lost.
                if (nxt_pend)
                begin
                    nxt_rst   = 1'b1;
                    nxt_cause = `WDIT_CAUSE_WDOG;
                end
                nxt_pend = 1'b0;
            end
            else
            begin
                nxt_win = win_ff - 9'h001;
            end
        end

        // Software writes take priority over the counter in their cycle.
        if (ctl_wr)
        begin
            nxt_intv = wr_ctl.intv;
            if (!locked)
            begin
                nxt_mode = wr_ctl.mode;
            end
            if (wr_ctl.en)
            begin
                nxt_en = 1'b1;
                if (!en_ff)
                begin
                    nxt_cnt  = `WDIT_CNT_RST;
                    nxt_key  = wdit_pkg::WDIT_KEY_IDLE;
                    nxt_pend = 1'b0;
                end
            end
            else if (!locked)
            begin
                nxt_en = 1'b0;
            end

            // The clear field is judged against the enable held before the
            // write, so enabling and clearing in one write clears nothing.
            if (en_ff)
            begin
                if (mode_ff == wdit_pkg::WDIT_TIMER)
                begin
                    if (wr_ctl.clr[`WDIT_TCLR_BIT])
                    begin
                        nxt_cnt = `WDIT_CNT_RST;
                    end
                end
                else if (wr_ctl.clr == `WDIT_KEY_FIRST)
                begin
                    nxt_key = wdit_pkg::WDIT_KEY_ARMED;
                    nxt_win = KEY_WIN;
                end
                else if (wr_ctl.clr == `WDIT_KEY_SECOND
                         && key_ff == wdit_pkg::WDIT_KEY_ARMED)
                begin
                    nxt_cnt   = `WDIT_CNT_RST;
                    nxt_key   = wdit_pkg::WDIT_KEY_IDLE;
                    nxt_pend  = 1'b0;
                    nxt_rst   = 1'b0;
                    nxt_cause = cause_ff;
                end
            end
        end

        // The clear field reads as zero so read-modify-write key
        // sequences see a clean nibble; the counter is never visible.
        nxt_rdata = {4'h0, nxt_en, nxt_mode, nxt_intv};
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_ff   <= `WDIT_CNT_RST;
            en_ff    <= 1'b0;
            mode_ff  <= wdit_pkg::WDIT_WATCHDOG;
            intv_ff  <= `WDIT_INT_32768;
            key_ff   <= wdit_pkg::WDIT_KEY_IDLE;
            win_ff   <= 9'h000;
            pend_ff  <= 1'b0;
            rst_ff   <= 1'b0;
            irq_ff   <= 1'b0;
            cause_ff <= `WDIT_CAUSE_NONE;
            rdata_ff <= `WDIT_CTL_RST;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;
            en_ff    <= nxt_en;
            mode_ff  <= nxt_mode;
            intv_ff  <= nxt_intv;
            key_ff   <= nxt_key;
            win_ff   <= nxt_win;
            pend_ff  <= nxt_pend;
            rst_ff   <= nxt_rst;
            irq_ff   <= nxt_irq;
            cause_ff <= nxt_cause;
            rdata_ff <= nxt_rdata;
        end
    end

    assign ctl_rdata    = rdata_ff;
    assign wdog_rst_req = rst_ff;
    assign rst_cause    = cause_ff;
    assign tmr_irq      = irq_ff;

endmodule

// *** verification/wdit_top_monitor.sv ***
// Port-level checker for the watchdog and interval timer.
`timescale 1ns/10ps
module wdit_top_monitor
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Inputs watched
    input wire logic       lf_clk,
    input wire logic       ctl_wr,
    input wire logic [7:0] ctl_wdata,
    // Outputs watched
    input wire logic [7:0] ctl_rdata,
    input wire logic       wdog_rst_req,
    input wire logic [1:0] rst_cause,
    input wire logic       tmr_irq
);
    logic [7:0] wd_ff;
    logic       lock;

    // The write data of each cycle is kept so readback can be compared a cycle later.
    always_ff @(posedge clk)
    begin
        wd_ff <= ctl_wdata;
    end

    assign lock = ctl_rdata[3] & ~ctl_rdata[2];

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_reset_clean: assert property ($rose(rstn) |->
        ctl_rdata == 8'h00 && !tmr_irq && !wdog_rst_req && rst_cause == 2'h0)
        else $error("outputs not clear after reset");
    a_write_seen: assert property (ctl_wr && !lock |=>
        ctl_rdata == {4'h0, wd_ff[3:0]}) else $error("write not reflected");
    a_lock_hold: assert property (lock |=> lock)
        else $error("running watchdog was stopped or switched");
    a_intv_live: assert property (ctl_wr && lock |=>
        ctl_rdata[1:0] == wd_ff[1:0]) else $error("interval not rewritten");
    a_no_wdog_irq: assert property (tmr_irq |-> ctl_rdata[2])
        else $error("interrupt outside timer mode");
    a_no_timer_rst: assert property (wdog_rst_req |-> lock)
        else $error("reset outside running watchdog");
    a_cause_set: assert property (wdog_rst_req |->
        rst_cause == 2'h2) else $error("reset cause not recorded");
    a_cause_held: assert property (rst_cause == 2'h2 |=>
        $stable(rst_cause)) else $error("reset cause lost");
    a_pulse_short: assert property (tmr_irq || wdog_rst_req |=>
        !tmr_irq && !wdog_rst_req) else $error("event pulse too long");
    a_idle_quiet: assert property (!ctl_rdata[3] [*2] |->
        !tmr_irq && !wdog_rst_req) else $error("event while stopped");

    c_irq: cover property (tmr_irq);
    c_rst: cover property (wdog_rst_req);
    c_locked_write: cover property (ctl_wr && lock);
    c_key_clear: cover property (ctl_wr && lock && ctl_wdata[7:4] == 4'h5);
endmodule

bind wdit_top wdit_top_monitor u_mon
(
    .clk          (clk),
    .rstn         (rstn),
    .lf_clk       (lf_clk),
    .ctl_wr       (ctl_wr),
    .ctl_wdata    (ctl_wdata),
    .ctl_rdata    (ctl_rdata),
    .wdog_rst_req (wdog_rst_req),
    .rst_cause    (rst_cause),
    .tmr_irq      (tmr_irq)
);

// *** verification/wdit_top_tb.sv ***
// Self-checking bench for the watchdog and interval timer.
`timescale 1ns/10ps
module wdit_top_tb;
    // The slow pin runs fast here so the 64 and 512 intervals fit a short run.
    localparam int LF_HALF = 3;
    logic       clk = 1'b0;
    logic       rstn;
    logic       lf_clk = 1'b0;
    logic       ctl_wr;
    logic [7:0] ctl_wdata;
    logic [7:0] ctl_rdata;
    logic       wdog_rst_req;
    logic [1:0] rst_cause;
    logic       tmr_irq;
    int         errors;
    int         checks_done;
    int         lf_cnt = 0;
    int         n;
    // Interval codes 01 and 00 are longer than the wait, so no event shows.
    logic [1:0] n_codes [2] = '{2'h1, 2'h0};

    wdit_top dut
    (
        .clk          (clk),
        .rstn         (rstn),
        .lf_clk       (lf_clk),
        .ctl_wr       (ctl_wr),
        .ctl_wdata    (ctl_wdata),
        .ctl_rdata    (ctl_rdata),
        .wdog_rst_req (wdog_rst_req),
        .rst_cause    (rst_cause),
        .tmr_irq      (tmr_irq)
    );

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
        if (lf_cnt == LF_HALF - 1)
            lf_clk <= ~lf_clk;
    end

    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        ctl_wr    <= 1'b1;
        ctl_wdata <= d;
        @(posedge clk);
        ctl_wr    <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic rd(input string nm, input logic [7:0] e);
        @(negedge clk);
        chk(nm, e, ctl_rdata);
    endtask

    task automatic rng(input string nm, input int v,
                       input int lo, input int hi);
        checks_done++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, v);
        end
    endtask

    // Counts cycles to the next interrupt or reset pulse, up to lim.
    task automatic wait_ev(input int lim, output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (k < lim && (tmr_irq | wdog_rst_req) !== 1'b1);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        rstn = 1'b0;
        ctl_wr = 1'b0;
        ctl_wdata = 8'h00;
        errors = 0;
        checks_done = 0;
        do_reset();
        rd("reset rdata", 8'h00);
        wr(8'h07);
        wait_ev(600, n);
        rng("disabled quiet", n, 600, 600);
        $display("Test reset done");
        wr(8'h0f);
        rd("timer rdata", 8'h0f);
        wait_ev(600, n);
        rng("first irq", n, 355, 395);
        wait_ev(600, n);
        rng("period 64", n, 384, 384);
        wr(8'h0e);
        wait_ev(4000, n);
        rng("interval change", n, 3055, 3075);
        wait_ev(4000, n);
        rng("period 512", n, 3072, 3072);
        $display("Test timer period done");
        repeat (1500) @(negedge clk);
        wr(8'h1e);
        wait_ev(4000, n);
        rng("timer clear", n, 3055, 3080);
        wr(8'h06);
        rd("stopped rdata", 8'h06);
        wait_ev(4000, n);
        rng("stopped quiet", n, 4000, 4000);
        wr(8'h0e);
        wait_ev(4000, n);
        rng("restart", n, 3055, 3080);
        foreach (n_codes[i])
        begin
            wr(8'h04 | n_codes[i]);
            wr(8'h0c | n_codes[i]);
            wait_ev(4000, n);
            rng("long interval", n, 4000, 4000);
        end
        $display("Test timer control done");
        do_reset();
        wr(8'h0b);
        rd("wdog rdata", 8'h0b);
        wr(8'h07);
        rd("wdog locked", 8'h0b);
        repeat (4)
        begin
            wait_ev(200, n);
            rng("no early reset", n, 200, 200);
            wr(8'hab);
            wr(8'h5b);
        end
        wait_ev(100, n);
        wr(8'h5b);
        wait_ev(400, n);
        rng("wdog expiry", n, 260, 300);
        chk("cause", 8'h02, {6'h00, rst_cause});
        // A new interval goes in together with a clear sequence.
        wr(8'haa);
        wr(8'h5a);
        rd("wdog new intv", 8'h0a);
        wait_ev(3200, n);
        rng("wdog period 512", n, 3060, 3076);
        wr(8'hab);
        wr(8'h5b);
        // First key just before expiry, second key just after it.
        repeat (360) @(negedge clk);
        wr(8'hab);
        wait_ev(30, n);
        rng("deferred expiry", n, 30, 30);
        wr(8'h5b);
        wait_ev(500, n);
        rng("late clear", n, 380, 390);
        // A window that lapses turns the held expiry into a reset.
        repeat (100) @(negedge clk);
        wr(8'hab);
        wait_ev(500, n);
        rng("window lapse", n, 380, 386);
        wr(8'h5b);
        wait_ev(400, n);
        rng("stale key", n, 278, 288);
        $display("Test watchdog done");
        end_of_test();
    end

    initial
    begin
        #(40 * 60000);
        errors++;
        $display("Watchdog span ran out");
        end_of_test();
    end
endmodule
